// >>> core/tcmc_defs.vh
// Purpose: Shared constants for the timer channel mode configuration block
// Assumes: Byte addresses on an 8-bit APB address
// Notes:   Offsets are word aligned; reserved bits read as zero unless stated
`ifndef TCMC_DEFS_VH
`define TCMC_DEFS_VH

// Register byte offsets
`define TCMC_OFF_MODE_BASE   8'h00
`define TCMC_OFF_IOCTL_BASE  8'h20
`define TCMC_OFF_START       8'h40
`define TCMC_OFF_PSC5        8'h44

// Address decode results
`define TCMC_KIND_NONE       3'h0
`define TCMC_KIND_MODE       3'h1
`define TCMC_KIND_IOCTL      3'h2
`define TCMC_KIND_START      3'h3
`define TCMC_KIND_PSC5       3'h4

// Counts and reset values
`define TCMC_NUM_CHAN        6
`define TCMC_NUM_IOCTL       8
`define TCMC_NUM_PIN         16
`define TCMC_MODE_RESET      6'h00
`define TCMC_MODE_FIXED_HI   2'h3
`define TCMC_IOCTL_RESET     8'h00
`define TCMC_START_RESET     6'h00
`define TCMC_PSC_RESET       3'h0

// Mode field bit positions
`define TCMC_BIT_BUF_B       5
`define TCMC_BIT_BUF_A       4

// Mode field encodings
`define TCMC_MD_NORMAL       4'h0
`define TCMC_MD_PWM1         4'h2
`define TCMC_MD_PWM2         4'h3

// Channel 5 prescale select codes
`define TCMC_PSC_DIV1        3'h0
`define TCMC_PSC_DIV4        3'h1
`define TCMC_PSC_DIV16       3'h2
`define TCMC_PSC_DIV64       3'h3
`define TCMC_PSC_EXT_A       3'h4
`define TCMC_PSC_EXT_C       3'h5
`define TCMC_PSC_DIV256      3'h6
`define TCMC_PSC_EXT_D       3'h7

// I/O control nibble encodings
`define TCMC_IO_OFF          2'h0
`define TCMC_IO_LOW          2'h1
`define TCMC_IO_HIGH         2'h2
`define TCMC_IO_TOGGLE       2'h3

`endif

// >>> core/tcmc_clksel.v
// Purpose: Channel 5 count clock selection and prescaling
// Assumes: External count clocks are asynchronous pins
// Notes:   Tick is a one-cycle pulse on CLK_I; held low in phase counting
`include "tcmc_defs.vh"

module tcmc_clksel #(
  parameter PRE_W = 8
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rstn_i,
  // Control
  input  wire [2:0] sel_i,
  input  wire       phase_mode_i,
  input  wire       run_i,
  // External count clock pins
  input  wire       ext_a_i,
  input  wire       ext_c_i,
  input  wire       ext_d_i,
  // Count tick
  output reg        tick_o
);

  reg [PRE_W-1:0] pre;
  reg [2:0]       sync1;
  reg [2:0]       sync2;
  reg [2:0]       sync3;
  reg             next_tick;
  wire [2:0]      ext_rise;

  // Second and third stages feed the edge detector
  assign ext_rise = sync2 & ~sync3;

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      pre   <= {PRE_W{1'b0}};
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
      tick_o <= 1'b0;
    end else begin
      pre   <= pre + {{(PRE_W-1){1'b0}}, 1'b1};
      sync1 <= {ext_d_i, ext_c_i, ext_a_i};
      sync2 <= sync1;
      sync3 <= sync2;
      tick_o <= next_tick;
    end
  end

  always @* begin
    case (sel_i)
      `TCMC_PSC_DIV1:   next_tick = 1'b1;
      `TCMC_PSC_DIV4:   next_tick = &pre[1:0];
      `TCMC_PSC_DIV16:  next_tick = &pre[3:0];
      `TCMC_PSC_DIV64:  next_tick = &pre[5:0];
      `TCMC_PSC_EXT_A:  next_tick = ext_rise[0];
      `TCMC_PSC_EXT_C:  next_tick = ext_rise[1];
      `TCMC_PSC_DIV256: next_tick = &pre[7:0];
      `TCMC_PSC_EXT_D:  next_tick = ext_rise[2];
      default:          next_tick = 1'b0;
    endcase
    if (phase_mode_i || !run_i) begin
      next_tick = 1'b0;
    end
  end

endmodule

// >>> core/tcmc_top.v
// Purpose: Mode, buffer pairing and I/O control registers of a six-channel timer
// Assumes: APB slave, zero wait states; compare and clear pulses are on CLK_I
// Notes:   Pin order ch0 A,B,C,D ch1 A,B ch2 A,B ch3 A,B,C,D ch4 A,B ch5 A,B
// Summary of operation
// - Channel 5 select: 000 /1, 001 /4, 010 /16, 011 /64, 100 A, 101 C, 110 /256, 111 D.
// - Channel 5 in phase counting mode ignores its prescale select.
// - Mode bits 7 and 6 read as one; writes to them are ignored.
// - Buffer B flag pairs B with D and suppresses D events.
// - Buffer A flag pairs A with C and suppresses C events.
// - Channels 1, 2, 4, 5 keep mode bits 5 and 4 read-only zero.
// - Both buffer flags clear after reset; A and B run unpaired.
// - Mode decode: 0 normal, 1 reserved, 2 PWM1, 3 PWM2, 4-7 phase.
// - Eight I/O control registers: two for channels 0 and 3, one otherwise.
// - Initial output level drives the pin while the run bit is zero.
// - In PWM mode 2 the initial level is driven at counter clear.
// - A buffering C or D register ignores its I/O control setting.
// - I/O control bits 7-4 set register B or D, bits 3-0 register A or C.
`include "tcmc_defs.vh"

module tcmc_top #(
  parameter NCH   = `TCMC_NUM_CHAN,
  parameter NIO   = `TCMC_NUM_IOCTL,
  parameter NPIN  = `TCMC_NUM_PIN,
  parameter PRE_W = 8
) (
  // Clock and reset
  input  wire            CLK_I,
  input  wire            RSTN_I,
  // APB slave
  input  wire            PSEL_I,
  input  wire            PENABLE_I,
  input  wire            PWRITE_I,
  input  wire [7:0]      PADDR_I,
  input  wire [31:0]     PWDATA_I,
  output reg  [31:0]     PRDATA_O,
  output wire            PREADY_O,
  output reg             PSLVERR_O,
  // External count clock pins
  input  wire            EXT_CLK_A_I,
  input  wire            EXT_CLK_C_I,
  input  wire            EXT_CLK_D_I,
  // Timer core events
  input  wire [NPIN-1:0] COMPARE_MATCH_I,
  input  wire [NCH-1:0]  COUNTER_CLEAR_I,
  // Channel state
  output wire            CH5_COUNT_TICK_O,
  output reg  [NCH-1:0]  COUNTER_RUN_O,
  output reg  [NCH-1:0]  MODE_NORMAL_O,
  output reg  [NCH-1:0]  MODE_PWM1_O,
  output reg  [NCH-1:0]  MODE_PWM2_O,
  output reg  [NCH-1:0]  MODE_PHASE_O,
  output reg  [NCH-1:0]  MODE_UNDEF_O,
  output reg  [1:0]      BUF_PAIR_A_O,
  output reg  [1:0]      BUF_PAIR_B_O,
  output reg  [NPIN-1:0] CAPTURE_EN_O,
  // Timer pins
  output reg  [NPIN-1:0] TIO_O,
  output reg  [NPIN-1:0] TIO_OE_O
);

  // Register storage
  reg  [5:0]     chan_mode_reg [0:NCH-1];
  reg  [7:0]     io_ctrl_reg   [0:NIO-1];
  reg  [NCH-1:0] run_reg;
  reg  [2:0]     psc5_reg;
  reg  [NPIN-1:0] pin_level;
  wire [NPIN-1:0] next_level;
  wire [NPIN-1:0] next_oe;
  wire [NPIN-1:0] next_cap;
  reg  [31:0]    next_rdata;
  reg  [2:0]     rd_kind;
  reg  [2:0]     wr_kind;
  wire [2:0]     idx;
  wire           setup;
  wire           wr_access;
  wire [1:0]     bfa;
  wire [1:0]     bfb;
  wire           ch5_phase;
  integer        i;
  integer        j;

  // Base offsets held as parameters so their upper bits can be sliced
  localparam [7:0] MODE_BASE  = `TCMC_OFF_MODE_BASE;
  localparam [7:0] IOCTL_BASE = `TCMC_OFF_IOCTL_BASE;

  // Decode address into register kind
  function [2:0] addr_kind;
    input [7:0] a;
    begin
      addr_kind = `TCMC_KIND_NONE;
      if (a[1:0] == 2'h0) begin
        if (a[7:5] == MODE_BASE[7:5] && a[4:2] < NCH)
          addr_kind = `TCMC_KIND_MODE;
        else if (a[7:5] == IOCTL_BASE[7:5])
          addr_kind = `TCMC_KIND_IOCTL;
        else if (a == `TCMC_OFF_START)
          addr_kind = `TCMC_KIND_START;
        else if (a == `TCMC_OFF_PSC5)
          addr_kind = `TCMC_KIND_PSC5;
      end
    end
  endfunction

  // Channels with C and D registers
  function has_cd;
    input integer ch;
    begin
      has_cd = (ch == 0) || (ch == 3);
    end
  endfunction

  // Channel owning a pin nibble
  function integer nib_chan;
    input integer k;
    begin
      if (k < 4)
        nib_chan = 0;
      else if (k < 8)
        nib_chan = (k - 4) / 2 + 1;
      else if (k < 12)
        nib_chan = 3;
      else
        nib_chan = (k - 12) / 2 + 4;
    end
  endfunction

  // Pin nibble acting as a buffer register
  function nib_buf;
    input integer k;
    input [1:0]   fa;
    input [1:0]   fb;
    begin
      case (k)
        2:       nib_buf = fa[0];
        3:       nib_buf = fb[0];
        10:      nib_buf = fa[1];
        11:      nib_buf = fb[1];
        default: nib_buf = 1'b0;
      endcase
    end
  endfunction

  // Phase counting codes 0100 to 0111
  function is_phase;
    input [3:0] md;
    begin
      is_phase = (md[3:2] == 2'h1);
    end
  endfunction

  // PWM mode 2 code
  function is_pwm2;
    input [3:0] md;
    begin
      is_pwm2 = (md == `TCMC_MD_PWM2);
    end
  endfunction

  // Reserved code 0001 or bit 3 set
  function is_undef;
    input [3:0] md;
    begin
      is_undef = md[3] || (md == 4'h1);
    end
  endfunction

  assign idx       = PADDR_I[4:2];
  assign setup     = PSEL_I && !PENABLE_I;
  assign wr_access = PSEL_I && PENABLE_I && PWRITE_I;
  // Zero wait states keeps the master simple
  assign PREADY_O  = 1'b1;

  // Only channels 0 and 3 can pair; the others keep the flags at zero
  assign bfa = {chan_mode_reg[3][`TCMC_BIT_BUF_A], chan_mode_reg[0][`TCMC_BIT_BUF_A]};
  assign bfb = {chan_mode_reg[3][`TCMC_BIT_BUF_B], chan_mode_reg[0][`TCMC_BIT_BUF_B]};

  // Channel 5 phase counting gates its prescaler
  assign ch5_phase = is_phase(chan_mode_reg[5][3:0]);

  always @* begin
    rd_kind = addr_kind(PADDR_I);
    wr_kind = addr_kind(PADDR_I);
    next_rdata = 32'h0000_0000;
    case (rd_kind)
      `TCMC_KIND_MODE: begin
        next_rdata = {24'h00_0000, `TCMC_MODE_FIXED_HI, chan_mode_reg[idx]};
      end
      `TCMC_KIND_IOCTL: begin
        next_rdata = {24'h00_0000, io_ctrl_reg[idx]};
      end
      `TCMC_KIND_START: begin
        next_rdata = {26'h000_0000, run_reg};
      end
      `TCMC_KIND_PSC5: begin
        next_rdata = {29'h0000_0000, psc5_reg};
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data and error captured in the setup cycle
  // So both stand unchanged through the access phase
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else if (setup) begin
      PRDATA_O  <= next_rdata;
      PSLVERR_O <= (rd_kind == `TCMC_KIND_NONE);
    end
  end

  // Register writes
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      for (i = 0; i < NCH; i = i + 1) begin
        chan_mode_reg[i] <= `TCMC_MODE_RESET;
      end
      for (i = 0; i < NIO; i = i + 1) begin
        io_ctrl_reg[i] <= `TCMC_IOCTL_RESET;
      end
      run_reg  <= `TCMC_START_RESET;
      psc5_reg <= `TCMC_PSC_RESET;
    end else if (wr_access) begin
      case (wr_kind)
        `TCMC_KIND_MODE: begin
          // Buffer bits fixed without C and D
          if (has_cd(idx))
            chan_mode_reg[idx] <= PWDATA_I[5:0];
          else
            chan_mode_reg[idx] <= {2'h0, PWDATA_I[3:0]};
        end
        `TCMC_KIND_IOCTL: begin
          io_ctrl_reg[idx] <= PWDATA_I[7:0];
        end
        `TCMC_KIND_START: begin
          run_reg <= PWDATA_I[NCH-1:0];
        end
        `TCMC_KIND_PSC5: begin
          psc5_reg <= PWDATA_I[2:0];
        end
        default: begin
          run_reg <= run_reg;
        end
      endcase
    end
  end

  // Per-pin control; nibble k lives in register k/2
  genvar k;
  generate
    for (k = 0; k < NPIN; k = k + 1) begin : g_pin
      // Odd nibbles are B or D, even are A or C
      wire [3:0] io = io_ctrl_reg[k / 2][(k % 2) * 4 +: 4];
      wire       ch_run = run_reg[nib_chan(k)];
      wire       pwm2 = is_pwm2(chan_mode_reg[nib_chan(k)][3:0]);
      wire       bufd = nib_buf(k, bfa, bfb);
      wire       is_out = !io[3] && (io[1:0] != `TCMC_IO_OFF) && !bufd;
      reg        lvl;
      always @* begin
        lvl = pin_level[k];
        if (!ch_run)
          lvl = io[2];
        // PWM mode 2 restarts at clear
        else if (pwm2 && COUNTER_CLEAR_I[nib_chan(k)])
          lvl = io[2];
        else if (is_out && COMPARE_MATCH_I[k]) begin
          case (io[1:0])
            `TCMC_IO_LOW:    lvl = 1'b0;
            `TCMC_IO_HIGH:   lvl = 1'b1;
            `TCMC_IO_TOGGLE: lvl = ~pin_level[k];
            default:         lvl = pin_level[k];
          endcase
        end
      end
      assign next_level[k] = lvl;
      assign next_oe[k]    = is_out;
      assign next_cap[k]   = io[3] && !bufd;
    end
  endgenerate

  // Registered state outputs
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pin_level     <= {NPIN{1'b0}};
      TIO_O         <= {NPIN{1'b0}};
      TIO_OE_O      <= {NPIN{1'b0}};
      CAPTURE_EN_O  <= {NPIN{1'b0}};
      COUNTER_RUN_O <= {NCH{1'b0}};
      MODE_NORMAL_O <= {NCH{1'b0}};
      MODE_PWM1_O   <= {NCH{1'b0}};
      MODE_PWM2_O   <= {NCH{1'b0}};
      MODE_PHASE_O  <= {NCH{1'b0}};
      MODE_UNDEF_O  <= {NCH{1'b0}};
      BUF_PAIR_A_O  <= 2'h0;
      BUF_PAIR_B_O  <= 2'h0;
    end else begin
      pin_level     <= next_level;
      TIO_O         <= next_level;
      TIO_OE_O      <= next_oe;
      CAPTURE_EN_O  <= next_cap;
      COUNTER_RUN_O <= run_reg;
      // Pairing reported for channels 0 and 3
      BUF_PAIR_A_O  <= bfa;
      BUF_PAIR_B_O  <= bfb;
      for (j = 0; j < NCH; j = j + 1) begin
        MODE_NORMAL_O[j] <= (chan_mode_reg[j][3:0] == `TCMC_MD_NORMAL);
        MODE_PWM1_O[j]   <= (chan_mode_reg[j][3:0] == `TCMC_MD_PWM1);
        MODE_PWM2_O[j]   <= is_pwm2(chan_mode_reg[j][3:0]);
        MODE_PHASE_O[j]  <= is_phase(chan_mode_reg[j][3:0]);
        // Reserved code 0001 and bit 3 set have no mode
        MODE_UNDEF_O[j]  <= is_undef(chan_mode_reg[j][3:0]);
      end
    end
  end

  tcmc_clksel #(
    .PRE_W        (PRE_W)
  ) u_clksel (
    .clk_i        (CLK_I),
    .rstn_i       (RSTN_I),
    .sel_i        (psc5_reg),
    .phase_mode_i (ch5_phase),
    .run_i        (run_reg[5]),
    .ext_a_i      (EXT_CLK_A_I),
    .ext_c_i      (EXT_CLK_C_I),
    .ext_d_i      (EXT_CLK_D_I),
    .tick_o       (CH5_COUNT_TICK_O)
  );

endmodule

// >>> testbench/tcmc_assertions.sv
// Purpose: Port-level checks of the mode block
// Assumes: One clock, synchronous active-low reset
// Notes:   Derived outputs lag a write by one extra edge
module tcmc_assertions #(
  parameter NCH  = 6,
  parameter NPIN = 16
) (
  // Clock, reset and bus
  input logic            CLK_I,
  input logic            RSTN_I,
  input logic            PSEL_I,
  input logic            PENABLE_I,
  input logic            PWRITE_I,
  input logic [7:0]      PADDR_I,
  input logic [31:0]     PWDATA_I,
  input logic [31:0]     PRDATA_O,
  input logic            PSLVERR_O,
  // Channel state
  input logic            CH5_COUNT_TICK_O,
  input logic [NCH-1:0]  COUNTER_RUN_O,
  input logic [NCH-1:0]  MODE_PWM2_O,
  input logic [NCH-1:0]  MODE_PHASE_O,
  input logic [1:0]      BUF_PAIR_A_O,
  input logic [1:0]      BUF_PAIR_B_O,
  input logic [NPIN-1:0] CAPTURE_EN_O,
  input logic [NPIN-1:0] TIO_OE_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  wire wr = PSEL_I && PENABLE_I && PWRITE_I;
  wire rs = PSEL_I && !PENABLE_I && !PWRITE_I;
  wire bad = |PADDR_I[1:0] || PADDR_I > 8'h44 || PADDR_I[7:3] == 5'h03;
  a_slverr_unmapped: assert property (
    PSEL_I && !PENABLE_I && bad |=> PSLVERR_O)
    else $error("no error on unmapped address");
  a_fixed_ones: assert property (
    rs && PADDR_I < 8'h18 && !bad |=> PRDATA_O[7:6] == 2'h3)
    else $error("mode bits 7:6 not one");
  a_narrow_ro: assert property (
    rs && PADDR_I < 8'h18 && !bad && PADDR_I != 8'h00 && PADDR_I != 8'h0C
    |=> PRDATA_O[5:4] == 2'h0)
    else $error("buffer bits set on narrow channel");
  a_pwm2_decode: assert property (
    wr && PADDR_I == 8'h08 |-> ##2 MODE_PWM2_O[2] == ($past(PWDATA_I[3:0], 2) == 4'h3))
    else $error("pwm2 decode wrong");
  a_phase_decode: assert property (
    wr && PADDR_I == 8'h14 |-> ##2 MODE_PHASE_O[5] == ($past(PWDATA_I[3:2], 2) == 2'h1))
    else $error("phase decode wrong");
  a_pair_follows: assert property (
    wr && PADDR_I == 8'h00 |-> ##2 BUF_PAIR_A_O[0] == $past(PWDATA_I[4], 2)
    && BUF_PAIR_B_O[0] == $past(PWDATA_I[5], 2))
    else $error("pair flags wrong");
  a_buf_c_quiet: assert property (
    BUF_PAIR_A_O[0] && $past(BUF_PAIR_A_O[0]) |-> !TIO_OE_O[2] && !CAPTURE_EN_O[2])
    else $error("buffer C still active");
  a_buf_d_quiet: assert property (
    BUF_PAIR_B_O[0] && $past(BUF_PAIR_B_O[0]) |-> !TIO_OE_O[3] && !CAPTURE_EN_O[3])
    else $error("buffer D still active");
  a_tick_gated: assert property (
    (!COUNTER_RUN_O[5] || MODE_PHASE_O[5]) [*3] |-> !CH5_COUNT_TICK_O)
    else $error("tick while gated");
endmodule

bind tcmc_top tcmc_assertions #(.NCH(NCH), .NPIN(NPIN)) chk_i (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PSLVERR_O(PSLVERR_O), .CH5_COUNT_TICK_O(CH5_COUNT_TICK_O),
  .COUNTER_RUN_O(COUNTER_RUN_O), .MODE_PWM2_O(MODE_PWM2_O), .MODE_PHASE_O(MODE_PHASE_O),
  .BUF_PAIR_A_O(BUF_PAIR_A_O), .BUF_PAIR_B_O(BUF_PAIR_B_O),
  .CAPTURE_EN_O(CAPTURE_EN_O), .TIO_OE_O(TIO_OE_O));

// >>> testbench/tcmc_ext_model.sv
// Purpose: Far-side model of the external count clock pins
// Assumes: A burst starts on go_i
// Notes:   Pins stand low between bursts, as a gated source would
module tcmc_ext_model (
  // Clock and start
  input  logic       clk_i,
  input  logic       go_i,
  // Count clock pins a, c, d
  output logic [2:0] ext_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 40;
  initial ext_o = 3'h0;
  // Distinct edge counts 3, 5, 7 tell the pins apart
  always @(posedge clk_i) begin
    if (go_i)
      n <= 0;
    else if (n < 40)
      n <= n + 1;
    ext_o[0] <= n < 12 && n[1];
    ext_o[1] <= n < 20 && n[1];
    ext_o[2] <= n < 28 && n[1];
  end
endmodule

// >>> testbench/tcmc_bench.sv
// Purpose: Self-checking bench of the mode block
// Assumes: Zero-wait APB slave at byte addresses
// Notes:   Ticks counted on the falling edge, where they are settled
module tcmc_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK_I, RSTN_I, PSEL_I, PENABLE_I, PWRITE_I, go, err;
  logic        PREADY_O, PSLVERR_O, CH5_COUNT_TICK_O;
  logic [7:0]  PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, q;
  logic [15:0] COMPARE_MATCH_I, CAPTURE_EN_O, TIO_O, TIO_OE_O;
  logic [5:0]  COUNTER_CLEAR_I, COUNTER_RUN_O, MODE_NORMAL_O, MODE_PWM1_O;
  logic [5:0]  MODE_PWM2_O, MODE_PHASE_O, MODE_UNDEF_O;
  logic [2:0]  ext;
  logic [1:0]  BUF_PAIR_A_O, BUF_PAIR_B_O;
  int          fail_count, comparisons, n;
  int          sel[5] = '{0, 1, 2, 3, 6};
  int          dv[5] = '{1, 4, 16, 64, 256};
  int          es[3] = '{4, 5, 7};

  tcmc_top dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .EXT_CLK_A_I(ext[0]),
    .EXT_CLK_C_I(ext[1]), .EXT_CLK_D_I(ext[2]), .COMPARE_MATCH_I(COMPARE_MATCH_I),
    .COUNTER_CLEAR_I(COUNTER_CLEAR_I), .CH5_COUNT_TICK_O(CH5_COUNT_TICK_O),
    .COUNTER_RUN_O(COUNTER_RUN_O), .MODE_NORMAL_O(MODE_NORMAL_O),
    .MODE_PWM1_O(MODE_PWM1_O), .MODE_PWM2_O(MODE_PWM2_O), .MODE_PHASE_O(MODE_PHASE_O),
    .MODE_UNDEF_O(MODE_UNDEF_O), .BUF_PAIR_A_O(BUF_PAIR_A_O), .BUF_PAIR_B_O(BUF_PAIR_B_O),
    .CAPTURE_EN_O(CAPTURE_EN_O), .TIO_O(TIO_O), .TIO_OE_O(TIO_OE_O));
  tcmc_ext_model pins (.clk_i(CLK_I), .go_i(go), .ext_o(ext));

  initial begin
    CLK_I = 1'b0;
    forever #20 CLK_I = ~CLK_I;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      fail_count++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge CLK_I);
  endtask

  // Request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge CLK_I);
      if (PREADY_O === 1'b1) break;
    end
    if (i == 20) begin
      fail_count++;
      final_report();
    end
    q = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    // Idle edge keeps back-to-back calls from driving psel twice in one step
    @(posedge CLK_I);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee = 1'b0);
    apb(1'b0, a, 32'h0);
    chk("rdata", e, q);
    chk("slverr", ee, err);
  endtask

  task automatic hit(input logic [15:0] m, input logic [5:0] c);
    COMPARE_MATCH_I <= m;
    COUNTER_CLEAR_I <= c;
    @(posedge CLK_I);
    COMPARE_MATCH_I <= 16'h0;
    COUNTER_CLEAR_I <= 6'h0;
    cyc(2);
  endtask

  task automatic ticks(input int w, input int e);
    n = 0;
    repeat (w) begin
      @(negedge CLK_I);
      if (CH5_COUNT_TICK_O === 1'b1) n++;
    end
    @(posedge CLK_I);
    chk("ticks", e, n);
  endtask

  initial begin
    {RSTN_I, PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I, go} = '0;
    COMPARE_MATCH_I = 16'h0;
    COUNTER_CLEAR_I = 6'h0;
    cyc(20);
    RSTN_I <= 1'b1;
    cyc(1);
    chk("pair", 0, {BUF_PAIR_B_O, BUF_PAIR_A_O});
    for (int c = 0; c < 6; c++) begin
      rd(8'(4 * c), 32'hC0);
      wr(8'(4 * c), 32'hF3);
      rd(8'(4 * c), c % 3 ? 32'hC3 : 32'hF3);
      wr(8'(4 * c), 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'(32 + 4 * i), 32'hA5 + i);
      rd(8'(32 + 4 * i), 32'hA5 + i);
      wr(8'(32 + 4 * i), 32'h0);
    end
    rd(8'h18, 32'h0, 1'b1);
    rd(8'h48, 32'h0, 1'b1);
    // Code 8 breaks the reserved bit on purpose
    for (int m = 0; m < 9; m++) begin
      wr(8'h04, 32'(m));
      cyc(2);
      chk("mode", {m == 0, m == 2, m == 3, m > 3 && m < 8, m == 1 || m == 8}, {MODE_NORMAL_O[1],
          MODE_PWM1_O[1], MODE_PWM2_O[1], MODE_PHASE_O[1], MODE_UNDEF_O[1]});
    end
    wr(8'h04, 32'h0);
    wr(8'h28, 32'h24);
    cyc(2);
    chk("idle", 2'h1, TIO_O[5:4]);
    wr(8'h40, 32'h02);
    hit(16'h0030, 6'h0);
    chk("pin", 3'h6, {TIO_OE_O[5], TIO_O[5], TIO_OE_O[4]});
    wr(8'h40, 32'h0);
    cyc(2);
    chk("stop", 0, TIO_O[5]);
    wr(8'h08, 32'h3);
    wr(8'h2C, 32'h07);
    wr(8'h40, 32'h04);
    cyc(2);
    chk("init", 1, TIO_O[6]);
    hit(16'h0040, 6'h0);
    chk("tgl", 0, TIO_O[6]);
    hit(16'h0040, 6'h04);
    chk("clr", 1, TIO_O[6]);
    wr(8'h40, 32'h0);
    wr(8'h00, 32'h30);
    wr(8'h24, 32'h86);
    wr(8'h40, 32'h01);
    hit(16'h000C, 6'h0);
    chk("buf", 6'h30, {BUF_PAIR_B_O[0], BUF_PAIR_A_O[0], TIO_OE_O[3:2], CAPTURE_EN_O[3:2]});
    wr(8'h40, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h40, 32'h01);
    hit(16'h000C, 6'h0);
    chk("nobuf", 6'h06, {BUF_PAIR_B_O[0], BUF_PAIR_A_O[0], TIO_OE_O[3:2], CAPTURE_EN_O[3:2]});
    wr(8'h40, 32'h20);
    for (int k = 0; k < 5; k++) begin
      wr(8'h44, 32'(sel[k]));
      rd(8'h44, 32'(sel[k]));
      cyc(4);
      ticks(256, 256 / dv[k]);
    end
    for (int k = 0; k < 3; k++) begin
      wr(8'h44, 32'(es[k]));
      cyc(4);
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      ticks(100, 3 + 2 * k);
    end
    wr(8'h44, 32'h0);
    wr(8'h40, 32'h0);
    wr(8'h14, 32'h4);
    wr(8'h40, 32'h20);
    cyc(4);
    chk("run", 32'h20, COUNTER_RUN_O);
    rd(8'h40, 32'h20);
    ticks(64, 0);
    final_report();
  end
endmodule
